// file: logic/jbs_chain.sv
// Boundary-scan test port: TAP, instruction, bypass, ID and boundary chain
//
// Contract
// RULE1 - Extest captures and drives; sample captures only, drives nothing.
// RULE2 - Bit 0 captures core reset-enable, updates reset pin enable.
// RULE3 - Bit 1 captures reset pin level, updates reset pin output; here the port 0 cell in bit 24 overrides that output.
// RULE4 - Bit 2 captures crystal input; its update does nothing.
// RULE5 - Bit 3 captures core pullup enable, updates port pullup enable.
// RULE6 - Bits 4-11 carry register-bus address, LSB in bit 4.
// RULE7 - Bits 12-19 carry register-bus data, LSB in bit 12.
// RULE8 - Bits 20-22 carry write, read, read-modify-write strobes.
// RULE9 - Port 0 pairs from bit 23: odd enable, next even data.
// RULE10 - Port 1 pairs on bits 39-54 likewise.
// RULE11 - Port 2 pairs on bits 55-70 likewise.
// RULE12 - Port 3 pairs on bits 71-86 likewise.
// RULE13 - Under extest every input to on-chip logic reads one.
// RULE14 - Sample allows observation and preload without driving pins.
// RULE15 - Bypass puts one bit between serial in and out.
// RULE16 - Identification selects 32-bit read-only register.
// RULE17 - ID: version 31-28, part 27-12, maker 11-1, one at bit 0.
// RULE18 - Boundary register is 87 bits between serial in and out.
// RULE19 - 16-bit instruction: extest 0000, sample 0002, bypass FFFF.
// RULE20 - Code 0004 selects identification, loaded at test reset.
// RULE21 - Capture in Capture-DR, shift per rising edge, drive on Update-DR.
// RULE22 - Bit 0 sits nearest serial out, shifted out first.
`timescale 1ns/10ps

module jbs_chain (
	// Clock, reset, enable
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic clk_en,
	// Test pins (test clock sampled by mclk)
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdo_oe_n,
	// Core, pin and bus side inputs of the cells
	input wire jbs_pkg::jbs_core_t core_in,
	input wire logic rst_pin_in,
	input wire logic crystal_in_pin,
	input wire logic [7:0] periph_reg_data_in,
	input wire logic [31:0] port_pin_in,
	// Pin and bus side of the cells
	output jbs_pkg::jbs_core_t pin_drive,
	output logic extest_active,
	// Inputs seen by on-chip logic
	output logic rst_to_core,
	output logic [7:0] data_to_core,
	output logic [31:0] port_to_core
);

	// ****************************************
	// State
	// ****************************************
	jbs_pkg::jbs_state_t r;
	jbs_pkg::jbs_state_t next_r;
	logic tck_rise;
	logic tck_fall;
	logic tms_s;
	logic tdi_s;
	logic sel_bsr;
	logic [86:0] cap;
	logic [86:0] upd_v;
	logic [31:0] id_word;
	logic [15:0] ir_next;
	logic sel_id;
	logic sel_byp;
	logic tdo_bit;

	// RULE17 identification layout
	assign id_word = {jbs_pkg::ID_VERSION, jbs_pkg::ID_PART,
		jbs_pkg::ID_MAKER, jbs_pkg::ID_LSB};

	// Edge seen as stage two leaves stage three;
	// stage three agrees one cycle later and holds
	assign tck_rise = r.sync.tck[1] & ~r.sync.tck[2];
	assign tms_s = r.sync.tms[2];
	assign tdi_s = r.sync.tdi[2];

	// ****************************************
	// Capture vector
	// ****************************************
	always_comb begin
		cap = '0;
		// RULE2 reset enable
		cap[jbs_pkg::BIT_RST_EN] = core_in.rst_en;
		// RULE3 reset pin level
		cap[jbs_pkg::BIT_RST_OUT] = rst_pin_in;
		// RULE4 crystal input
		cap[jbs_pkg::BIT_XTAL] = crystal_in_pin;
		// RULE5 pullup enable
		cap[jbs_pkg::BIT_PULLUP] = core_in.pullup_en;
		// RULE6 address lines
		cap[jbs_pkg::BIT_ADDR +: 8] = core_in.addr;
		// RULE7 data read from bus
		cap[jbs_pkg::BIT_DATA +: 8] = periph_reg_data_in;
		// RULE8 strobes
		cap[jbs_pkg::BIT_WR] = core_in.wr;
		cap[jbs_pkg::BIT_RD] = core_in.rd;
		cap[jbs_pkg::BIT_RMW] = core_in.rmw;
		// RULE9 RULE10 RULE11 RULE12 paired port cells
		for (int i = 0; i < 32; i++) begin
			cap[jbs_pkg::BIT_PORT0 + 2 * i] = core_in.oe[i];
			cap[jbs_pkg::BIT_PORT0 + 2 * i + 1] = port_pin_in[i];
		end
	end

	// ****************************************
	// Instruction decode
	// ****************************************
	// Unknown codes fall back to bypass, so a stray
	// instruction never exposes the boundary cells
	always_comb begin
		sel_bsr = 1'b0;
		sel_id = 1'b0;
		sel_byp = 1'b0;
		case (r.ir)
			// RULE19 extest and sample share the chain
			jbs_pkg::IR_EXTEST: begin
				sel_bsr = 1'b1;
			end
			jbs_pkg::IR_SAMPLE: begin
				sel_bsr = 1'b1;
			end
			// RULE16 identification word
			jbs_pkg::IR_IDENT: begin
				sel_id = 1'b1;
			end
			// RULE15 bypass and every other code
			default: begin
				sel_byp = 1'b1;
			end
		endcase
	end

	// ****************************************
	// Serial output select
	// ****************************************
	always_comb begin
		tdo_bit = 1'b0;
		// RULE22 bit 0 of the chosen register leaves first
		if (r.tap == jbs_pkg::ST_SHIFT_IR) begin
			tdo_bit = r.ir_shift[0];
		end else if (sel_bsr) begin
			tdo_bit = r.bsr[0];
		end else if (sel_id) begin
			tdo_bit = r.id_shift[0];
		end else if (sel_byp) begin
			tdo_bit = r.bypass;
		end
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		next_r = r;
		upd_v = r.upd;
		ir_next = r.ir;
		next_r.sync.tck = {r.sync.tck[1:0], tck};
		next_r.sync.tms = {r.sync.tms[1:0], tms};
		next_r.sync.tdi = {r.sync.tdi[1:0], tdi};
		if (tck_rise) begin
			case (r.tap)
				jbs_pkg::ST_RESET: next_r.tap = tms_s ? jbs_pkg::ST_RESET
					: jbs_pkg::ST_IDLE;
				jbs_pkg::ST_IDLE: next_r.tap = tms_s ? jbs_pkg::ST_SEL_DR
					: jbs_pkg::ST_IDLE;
				jbs_pkg::ST_SEL_DR: next_r.tap = tms_s ? jbs_pkg::ST_SEL_IR
					: jbs_pkg::ST_CAP_DR;
				jbs_pkg::ST_CAP_DR: next_r.tap = tms_s ? jbs_pkg::ST_EXIT1_DR
					: jbs_pkg::ST_SHIFT_DR;
				jbs_pkg::ST_SHIFT_DR: next_r.tap = tms_s ? jbs_pkg::ST_EXIT1_DR
					: jbs_pkg::ST_SHIFT_DR;
				jbs_pkg::ST_EXIT1_DR: next_r.tap = tms_s ? jbs_pkg::ST_UPD_DR
					: jbs_pkg::ST_PAUSE_DR;
				jbs_pkg::ST_PAUSE_DR: next_r.tap = tms_s ? jbs_pkg::ST_EXIT2_DR
					: jbs_pkg::ST_PAUSE_DR;
				jbs_pkg::ST_EXIT2_DR: next_r.tap = tms_s ? jbs_pkg::ST_UPD_DR
					: jbs_pkg::ST_SHIFT_DR;
				jbs_pkg::ST_UPD_DR: next_r.tap = tms_s ? jbs_pkg::ST_SEL_DR
					: jbs_pkg::ST_IDLE;
				jbs_pkg::ST_SEL_IR: next_r.tap = tms_s ? jbs_pkg::ST_RESET
					: jbs_pkg::ST_CAP_IR;
				jbs_pkg::ST_CAP_IR: next_r.tap = tms_s ? jbs_pkg::ST_EXIT1_IR
					: jbs_pkg::ST_SHIFT_IR;
				jbs_pkg::ST_SHIFT_IR: next_r.tap = tms_s ? jbs_pkg::ST_EXIT1_IR
					: jbs_pkg::ST_SHIFT_IR;
				jbs_pkg::ST_EXIT1_IR: next_r.tap = tms_s ? jbs_pkg::ST_UPD_IR
					: jbs_pkg::ST_PAUSE_IR;
				jbs_pkg::ST_PAUSE_IR: next_r.tap = tms_s ? jbs_pkg::ST_EXIT2_IR
					: jbs_pkg::ST_PAUSE_IR;
				jbs_pkg::ST_EXIT2_IR: next_r.tap = tms_s ? jbs_pkg::ST_UPD_IR
					: jbs_pkg::ST_SHIFT_IR;
				jbs_pkg::ST_UPD_IR: next_r.tap = tms_s ? jbs_pkg::ST_SEL_DR
					: jbs_pkg::ST_IDLE;
				default: next_r.tap = jbs_pkg::ST_RESET;
			endcase
			// RULE21 capture then shift, one bit per rising edge
			case (r.tap)
				jbs_pkg::ST_CAP_DR: begin
					if (sel_bsr)
						next_r.bsr = cap;
					// RULE16 identification loaded for shifting
					if (sel_id)
						next_r.id_shift = id_word;
					// RULE15 bypass captures zero
					if (sel_byp)
						next_r.bypass = 1'b0;
				end
				jbs_pkg::ST_SHIFT_DR: begin
					// RULE18 RULE22 bit 0 leaves first
					if (sel_bsr)
						next_r.bsr = {tdi_s, r.bsr[86:1]};
					if (sel_id)
						next_r.id_shift = {tdi_s, r.id_shift[31:1]};
					if (sel_byp)
						next_r.bypass = tdi_s;
				end
				jbs_pkg::ST_CAP_IR: begin
					next_r.ir_shift = {14'h0000, jbs_pkg::IR_CAPTURE};
				end
				jbs_pkg::ST_SHIFT_IR: begin
					next_r.ir_shift = {tdi_s, r.ir_shift[15:1]};
				end
				jbs_pkg::ST_UPD_IR: begin
					ir_next = r.ir_shift;
				end
				jbs_pkg::ST_UPD_DR: begin
					// RULE14 preload holds shifted data, not yet driven
					if (sel_bsr)
						upd_v = r.bsr;
				end
				jbs_pkg::ST_RESET: begin
					// RULE20 identification after test reset
					ir_next = jbs_pkg::IR_RESET;
				end
				default: begin
				end
			endcase
			if (r.tap == jbs_pkg::ST_RESET && tms_s)
				ir_next = jbs_pkg::IR_RESET;
			next_r.ir = ir_next;
			next_r.upd = upd_v;
			// RULE1 only extest drives updated cells
			next_r.extest = (ir_next == jbs_pkg::IR_EXTEST) &&
				(next_r.tap != jbs_pkg::ST_RESET);
		end
		// TDO changes on falling test clock, as the standard expects
		if (tck_fall) begin
			next_r.tdo_oe_n = !(r.tap == jbs_pkg::ST_SHIFT_DR ||
				r.tap == jbs_pkg::ST_SHIFT_IR);
			next_r.tdo = tdo_bit;
		end
		// RULE1 RULE2 RULE3 RULE5..RULE12 drive from update stage
		if (r.extest) begin
			next_r.drive.rst_en = r.upd[jbs_pkg::BIT_RST_EN];
			// Limitation: reset pin output shares the port 0
			// output slot, and the port cell below wins
			next_r.drive.out[0] = r.upd[jbs_pkg::BIT_RST_OUT];
			next_r.drive.pullup_en = r.upd[jbs_pkg::BIT_PULLUP];
			next_r.drive.addr = r.upd[jbs_pkg::BIT_ADDR +: 8];
			next_r.drive.data = r.upd[jbs_pkg::BIT_DATA +: 8];
			next_r.drive.wr = r.upd[jbs_pkg::BIT_WR];
			next_r.drive.rd = r.upd[jbs_pkg::BIT_RD];
			next_r.drive.rmw = r.upd[jbs_pkg::BIT_RMW];
			for (int i = 0; i < 32; i++) begin
				next_r.drive.oe[i] = r.upd[jbs_pkg::BIT_PORT0 + 2 * i];
				next_r.drive.out[i] = r.upd[jbs_pkg::BIT_PORT0 + 2 * i + 1];
			end
		end else begin
			next_r.drive = core_in;
		end
	end

	assign tck_fall = r.sync.tck[2] & ~r.sync.tck[1];

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			r <= '{sync: '0, tap: jbs_pkg::ST_RESET, ir_shift: '0,
				ir: jbs_pkg::IR_RESET, bsr: '0, upd: '0, id_shift: '0,
				bypass: 1'b0, tdo: 1'b0, tdo_oe_n: 1'b1, extest: 1'b0,
				drive: '0};
			rst_to_core <= 1'b1;
			data_to_core <= '0;
			port_to_core <= '0;
		end else if (clk_en) begin
			r <= next_r;
			// RULE13 extest forces core inputs to one
			rst_to_core <= r.extest ? 1'b1 : rst_pin_in;
			data_to_core <= r.extest ? 8'hFF : periph_reg_data_in;
			port_to_core <= r.extest ? 32'hFFFFFFFF : port_pin_in;
		end
	end

	assign tdo = r.tdo;
	assign tdo_oe_n = r.tdo_oe_n;
	assign pin_drive = r.drive;
	assign extest_active = r.extest;

endmodule // jbs_chain

// file: logic/jbs_pkg.sv
// Package: constants and types of the boundary-scan test port
package jbs_pkg;

	// ****************************************
	// Instruction register
	// ****************************************
	localparam int IR_WIDTH = 16;
	localparam logic [15:0] IR_EXTEST = 16'h0000;
	localparam logic [15:0] IR_SAMPLE = 16'h0002;
	localparam logic [15:0] IR_IDENT = 16'h0004;
	localparam logic [15:0] IR_BYPASS = 16'hFFFF;
	localparam logic [15:0] IR_RESET = 16'h0004;
	localparam logic [1:0] IR_CAPTURE = 2'h1;

	// ****************************************
	// Boundary register layout
	// ****************************************
	localparam int BSR_LEN = 87;
	localparam int BIT_RST_EN = 0;
	localparam int BIT_RST_OUT = 1;
	localparam int BIT_XTAL = 2;
	localparam int BIT_PULLUP = 3;
	localparam int BIT_ADDR = 4;
	localparam int BIT_DATA = 12;
	localparam int BIT_WR = 20;
	localparam int BIT_RD = 21;
	localparam int BIT_RMW = 22;
	localparam int BIT_PORT0 = 23;
	localparam int PORT_SPAN = 16;
	localparam int NUM_PORTS = 4;

	// ****************************************
	// Identification fields (values arbitrary)
	// ****************************************
	localparam logic [3:0] ID_VERSION = 4'h6;
	localparam logic [15:0] ID_PART = 16'h0ABC;
	localparam logic [10:0] ID_MAKER = 11'h155;
	localparam logic [0:0] ID_LSB = 1'h1;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [3:0] {
		ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
		ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR,
		ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
	} jbs_tap_t;

	// Core side of the boundary cells
	typedef struct packed {
		logic rst_en;
		logic pullup_en;
		logic [7:0] addr;
		logic [7:0] data;
		logic wr;
		logic rd;
		logic rmw;
		logic [31:0] oe;
		logic [31:0] out;
	} jbs_core_t;

	// Synchroniser stages of the test pins
	typedef struct packed {
		logic [2:0] tck;
		logic [2:0] tms;
		logic [2:0] tdi;
	} jbs_sync_t;

	typedef struct packed {
		jbs_sync_t sync;
		jbs_tap_t tap;
		logic [15:0] ir_shift;
		logic [15:0] ir;
		logic [86:0] bsr;
		logic [86:0] upd;
		logic [31:0] id_shift;
		logic bypass;
		logic tdo;
		logic tdo_oe_n;
		logic extest;
		jbs_core_t drive;
	} jbs_state_t;

endpackage

// file: test/jbs_chain_sva.sv
// Assertions on the boundary-scan chain ports
`timescale 1ns/10ps
module jbs_chain_sva (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// Watched ports
	input wire jbs_pkg::jbs_core_t core_in,
	input wire jbs_pkg::jbs_core_t pin_drive,
	input wire logic rst_pin_in,
	input wire logic [7:0] periph_reg_data_in,
	input wire logic [31:0] port_pin_in,
	input wire logic extest_active,
	input wire logic tdo_oe_n,
	input wire logic rst_to_core,
	input wire logic [7:0] data_to_core,
	input wire logic [31:0] port_to_core
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!reset_n);
	// Two cycles in one mode so registered outputs have settled
	sequence s_ext;
		extest_active ##1 extest_active;
	endsequence
	sequence s_norm;
		!extest_active ##1 !extest_active;
	endsequence
	a_reset_quiet: assert property ($rose(reset_n) |-> tdo_oe_n &&
		!extest_active && rst_to_core) else $error("bad state after reset");
	a_force_port: assert property (s_ext |-> &port_to_core)
		else $error("port inputs not forced high");
	a_force_data: assert property (s_ext |-> &data_to_core)
		else $error("data inputs not forced high");
	a_force_rst: assert property (s_ext |-> rst_to_core)
		else $error("reset input not forced high");
	a_sample_pass: assert property (s_norm |->
		pin_drive == $past(core_in)) else $error("pins not left to core");
	a_port_pass: assert property (s_norm |->
		port_to_core == $past(port_pin_in)) else $error("port input lost");
	a_data_pass: assert property (s_norm |->
		data_to_core == $past(periph_reg_data_in)) else $error("data lost");
	a_rst_pass: assert property (s_norm |->
		rst_to_core == $past(rst_pin_in)) else $error("reset input lost");
endmodule // jbs_chain_sva

bind jbs_chain jbs_chain_sva jbs_chain_sva_i (.mclk, .reset_n, .core_in,
	.pin_drive, .rst_pin_in, .periph_reg_data_in, .port_pin_in,
	.extest_active, .tdo_oe_n, .rst_to_core, .data_to_core, .port_to_core);

// file: test/jbs_host.sv
// Behavioural test controller on the far side of the test port
`timescale 1ns/10ps
module jbs_host (
	// Test pins
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo,
	input wire logic tdo_oe_n
);
	// Released serial out must not read as a plausible bit
	wire tdo_line = tdo_oe_n ? ~tdi : tdo;
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end
	// one bit per rising edge, clock still between calls
	task automatic step(input logic m, input logic d, output logic q);
		tms = m;
		tdi = d;
		#400 tck = 1'b1;
		#200 q = tdo_line;
		#200 tck = 1'b0;
	endtask
	task automatic tap_reset();
		logic q;
		repeat (5) step(1'b1, 1'b0, q);
		step(1'b0, 1'b0, q);
	endtask
	task automatic scan(input logic ir, input logic [86:0] din, input int n,
		output logic [86:0] dout);
		logic q;
		dout = '0;
		step(1'b1, 1'b0, q);
		if (ir) begin
			step(1'b1, 1'b0, q);
		end
		step(1'b0, 1'b0, q);
		step(1'b0, 1'b0, q);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], q);
			dout[i] = q;
		end
		step(1'b1, 1'b0, q);
		step(1'b0, 1'b0, q);
	endtask
endmodule // jbs_host

// file: test/jbs_chain_test.sv
// Self-checking bench of the boundary-scan chain
`timescale 1ns/10ps
module jbs_chain_test;
	logic mclk, reset_n, clk_en, tck, tms, tdi, tdo, tdo_oe_n;
	logic rst_pin_in, crystal_in_pin, extest_active, rst_to_core;
	logic [7:0] periph_reg_data_in, data_to_core;
	logic [31:0] port_pin_in, port_to_core, seed;
	logic [86:0] seen, r, p;
	logic [86:0] exp_q[$];
	jbs_pkg::jbs_core_t core_in, pin_drive, e;
	int err_count, n_tests;
	event got;
	jbs_chain jbs_chain_i (.mclk(mclk), .reset_n(reset_n), .clk_en(clk_en),
		.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
		.core_in(core_in), .rst_pin_in(rst_pin_in),
		.crystal_in_pin(crystal_in_pin), .periph_reg_data_in(periph_reg_data_in),
		.port_pin_in(port_pin_in), .pin_drive(pin_drive),
		.extest_active(extest_active), .rst_to_core(rst_to_core),
		.data_to_core(data_to_core), .port_to_core(port_to_core));
	jbs_host jbs_host_i (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
		.tdo_oe_n(tdo_oe_n));
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic rand_in();
		logic [127:0] v;
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			v = {v[95:0], seed};
		end
		p = v[127:41];
		@(posedge mclk);
		core_in <= jbs_pkg::jbs_core_t'(v[84:0]);
		{rst_pin_in, crystal_in_pin, periph_reg_data_in} <= v[94:85];
		port_pin_in <= v[126:95];
		@(posedge mclk);
	endtask
	function automatic logic [86:0] cap();
		logic [86:0] c;
		c[22:0] = {core_in.rmw, core_in.rd, core_in.wr, periph_reg_data_in,
			core_in.addr, core_in.pullup_en, crystal_in_pin, rst_pin_in,
			core_in.rst_en};
		for (int i = 0; i < 32; i++) begin
			c[23 + 2 * i] = core_in.oe[i];
			c[24 + 2 * i] = port_pin_in[i];
		end
		return c;
	endfunction
	task automatic note(input logic [86:0] x, input logic [86:0] s);
		exp_q.push_back(x);
		seen = s;
		->got;
		#1;
	endtask
	task automatic chk(input logic [86:0] s, input logic [86:0] x);
		n_tests++;
		if (s !== x) begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, s, x);
		end
	endtask
	always @(got) begin
		chk(seen, exp_q.pop_front());
	end
	task automatic ir(input logic [15:0] c);
		jbs_host_i.scan(1'b1, 87'(c), 16, r);
		note(87'(jbs_pkg::IR_CAPTURE), 87'(r[1:0]));
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (90000) @(posedge mclk);
		err_count++;
		wrap_up();
	end
	initial begin
		{reset_n, rst_pin_in, crystal_in_pin} = 3'h2;
		clk_en = 1'b1;
		core_in = '0;
		periph_reg_data_in = '0;
		port_pin_in = '0;
		seed = 32'h00000049;
		err_count = 0;
		n_tests = 0;
		repeat (16) @(posedge mclk);
		reset_n <= 1'b1;
		jbs_host_i.tap_reset();
		jbs_host_i.scan(1'b0, '0, 32, r);
		note({55'h0, jbs_pkg::ID_VERSION, jbs_pkg::ID_PART, jbs_pkg::ID_MAKER,
			jbs_pkg::ID_LSB}, r);
		$display("test ident done");
		ir(jbs_pkg::IR_BYPASS);
		rand_in();
		jbs_host_i.scan(1'b0, p, 9, r);
		note(87'({p[7:0], 1'b0}), 87'(r[8:0]));
		$display("test bypass done");
		ir(jbs_pkg::IR_SAMPLE);
		rand_in();
		jbs_host_i.scan(1'b0, p, 87, r);
		note(cap(), r);
		jbs_host_i.scan(1'b0, '0, 87, r);
		note(cap(), r);
		$display("test sample done");
		ir(jbs_pkg::IR_EXTEST);
		rand_in();
		jbs_host_i.scan(1'b0, p, 87, r);
		note(cap(), r);
		{e.rmw, e.rd, e.wr, e.data, e.addr, e.pullup_en} = p[22:3];
		e.rst_en = p[0];
		for (int i = 0; i < 32; i++) begin
			e.oe[i] = p[23 + 2 * i];
			e.out[i] = p[24 + 2 * i];
		end
		note(87'(e[84:1]), 87'(pin_drive[84:1]));
		rand_in();
		note(87'(e[84:1]), 87'(pin_drive[84:1]));
		$display("test extest done");
		ir(jbs_pkg::IR_SAMPLE);
		rand_in();
		wrap_up();
	end
endmodule // jbs_chain_test
